// ---- src/crg_top.sv ----
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "crg_map.svh"
// Summary of operation
// RQ1: Reset pin low clears every control bit.
// RQ2: Words arriving during reset are discarded.
// RQ3: After reset, register stays zero until loaded.
// RQ4: Mute bit set drives microphone mute output.
// RQ5: Power-down blocks shifting and loading new words.
// RQ6: Leaving power-down forces all eight bits zero.
// RQ7: Clear is async, release synchronous per domain.
// RQ8: Eight bits shift in MSB first, rising edges.
// RQ9: Strobe rising edge transfers shifted word.
// RQ10: Volume low nibble, mute 4, range 5, mode top.
// RQ11: Mode 00 voice, 01 receive, 1x idle.
module crg_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,               // System clock, 50 MHz.
  input  wire logic              reset_n,           // Asynchronous reset, active low.
  input  wire logic              psel,              // APB select.
  input  wire logic              penable,           // APB access phase.
  input  wire logic              pwrite,            // APB write when high.
  input  wire logic [ADDR_W-1:0] paddr,             // APB byte address.
  input  wire logic [31:0]       pwdata,            // APB write data.
  output logic      [31:0]       prdata,            // APB read data.
  output logic                   pready,            // APB ready.
  output logic                   pslverr,           // APB error, unmapped address.
  input  wire logic              serial_clk,        // Serial port clock from the host.
  input  wire logic              serial_data,       // Serial port data.
  input  wire logic              load_strobe,       // Low while shifting, rise loads.
  input  wire logic              reset_hold_input,  // Register reset, active low.
  input  wire logic              power_down_input,  // Power-down, active high.
  output logic                   mic_mute_q,        // Microphone mute control.
  output logic                   range_narrow_q,    // High selects the narrow range.
  output logic      [3:0]        volume_q,          // Receive volume setting.
  output logic                   volume_active_q,   // Volume applies, forced receive.
  output logic                   voice_switch_q,    // Voice-activated switching.
  output logic                   force_receive_q,   // Forced receive mode.
  output logic                   force_idle_q       // Forced idle mode.
);

  localparam int WB = `CRG_WORD_BITS;

  // Elaboration check: the field layout only fits an eight-bit word.
  if (WB != 8) begin : g_word_check
    $error("Control word must be eight bits wide");
  end
  if (ADDR_W < 4) begin : g_addr_check
    $error("Address must reach the configuration register");
  end

  // Mode decode; both upper codes mean idle.
  function automatic crg_pkg::crg_mode_type mode_of(input logic [WB-1:0] w);
    mode_of = crg_pkg::crg_mode_type'(w[`CRG_MODE_MSB:`CRG_MODE_LSB]);
  endfunction : mode_of

  // Gate that holds both domains in reset: pin reset, power-down or system reset.
  logic gate_n;
  assign gate_n = reset_n & reset_hold_input & ~power_down_input; // RQ7

  // ------------------------------------------------------------------
  // Link domain: the shift stage on the host's serial clock.
  // ------------------------------------------------------------------
  logic          link_rst_n;
  logic [WB-1:0] shift_q;

  crg_rst_sync u_link_rst (
    .clk    (serial_clk),
    .arst_n (gate_n),
    .rst_n  (link_rst_n)
  );

  // Bits enter MSB first while the strobe is low; a high strobe freezes the stage
  // so the other domain can copy it. The clock may stop, nothing waits for it.
  always_ff @(posedge serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_q <= `CRG_CTRL_RESET; // RQ2 RQ5
    end else if (!load_strobe) begin
      shift_q <= {shift_q[WB-2:0], serial_data}; // RQ8
    end
  end

  // Each low-strobe edge moves the data bit into the bottom of the stage.
  shift_in_a: assert property (@(posedge serial_clk) disable iff (!link_rst_n) // RQ8
    !load_strobe |=> shift_q[0] == $past(serial_data) && shift_q[WB-1:1] == $past(shift_q[WB-2:0]))
    else $error("Serial bit not shifted in order");

  // ------------------------------------------------------------------
  // System domain: control register and its crossing.
  // ------------------------------------------------------------------
  logic ctrl_rst_n;

  crg_rst_sync u_ctrl_rst (
    .clk    (clk),
    .arst_n (gate_n),
    .rst_n  (ctrl_rst_n)
  );

  // Pins and strobe pass two flops before the edge detect and status word read them. The strobe idles
  // high, so it travels inverted: the synchroniser's reset value then already
  // reads as a high strobe, and leaving reset cannot fake a load.
  logic [2:0] pins_s;

  crg_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({~load_strobe, ~reset_hold_input, power_down_input}),
    .sync_out (pins_s)
  );

  logic strobe_s;
  logic hold_s;
  logic pd_s;
  assign strobe_s = ~pins_s[2];
  assign hold_s   = pins_s[1];
  assign pd_s     = pins_s[0];

  // Previous strobe level for edge detection; it resets to the idle high level.
  logic strobe_prev_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= strobe_s;
    end
  end

  logic strobe_rise;
  assign strobe_rise = strobe_s & ~strobe_prev_q;

  // The shift stage is frozen while the strobe is high, so the copy taken three
  // clocks after the rise is stable; this is why the strobe must stay high a while.
  logic [WB-1:0] ctrl_q;
  always_ff @(posedge clk or negedge ctrl_rst_n) begin
    if (!ctrl_rst_n) begin
      ctrl_q <= `CRG_CTRL_RESET; // RQ1 RQ3 RQ6
    end else if (strobe_rise) begin
      ctrl_q <= shift_q; // RQ9
    end
  end

  // Software override for the microphone mute, kept across pin resets.
  logic mute_force_q;

  // Outputs are registered copies of the control word and its decode; the mute output also ORs in the software override.
  always_ff @(posedge clk or negedge ctrl_rst_n) begin
    if (!ctrl_rst_n) begin
      mic_mute_q      <= 1'b0;
      range_narrow_q  <= 1'b0;
      volume_q        <= 4'h0;
      volume_active_q <= 1'b0;
      voice_switch_q  <= 1'b1;
      force_receive_q <= 1'b0;
      force_idle_q    <= 1'b0;
    end else begin
      mic_mute_q      <= ctrl_q[`CRG_MUTE_BIT] | mute_force_q; // RQ4
      range_narrow_q  <= ctrl_q[`CRG_RANGE_BIT]; // RQ10
      volume_q        <= ctrl_q[`CRG_VOL_MSB:`CRG_VOL_LSB]; // RQ10
      volume_active_q <= (mode_of(ctrl_q) == crg_pkg::CRG_MODE_RECEIVE); // RQ11
      voice_switch_q  <= (mode_of(ctrl_q) == crg_pkg::CRG_MODE_VOICE); // RQ11
      force_receive_q <= (mode_of(ctrl_q) == crg_pkg::CRG_MODE_RECEIVE); // RQ11
      force_idle_q    <= (mode_of(ctrl_q) == crg_pkg::CRG_MODE_IDLE_A) ||
                         (mode_of(ctrl_q) == crg_pkg::CRG_MODE_IDLE_B); // RQ11
    end
  end

  // Load bookkeeping: a sticky flag and a wrapping count of accepted words.
  logic       loaded_q;
  logic [7:0] load_cnt_q;
  logic       loaded_clr;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_cnt_q <= 8'h00;
    end else if (strobe_rise && ctrl_rst_n) begin
      load_cnt_q <= load_cnt_q + 8'h01;
    end
  end

  // A load in the same cycle as the software clear keeps the flag set.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_q <= 1'b0;
    end else if (strobe_rise && ctrl_rst_n) begin
      loaded_q <= 1'b1;
    end else if (loaded_clr) begin
      loaded_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // APB slave: zero-wait, answers in the first access cycle.
  // ------------------------------------------------------------------
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_cfg;
  assign setup    = psel & ~penable;
  assign access   = psel & penable & pready;
  assign hit_ctrl = (paddr == ADDR_W'(`CRG_OFF_CTRL_WORD));
  assign hit_stat = (paddr == ADDR_W'(`CRG_OFF_STATUS));
  assign hit_cfg  = (paddr == ADDR_W'(`CRG_OFF_CONFIG));

  // Status word seen by software.
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CRG_ST_PWR_DOWN] = pd_s;
    status_word[`CRG_ST_RST_HOLD] = hold_s;
    status_word[`CRG_ST_LOADED] = loaded_q;
    status_word[`CRG_ST_CNT_MSB:`CRG_ST_CNT_LSB] = load_cnt_q;
  end

  // Ready, error and read data are prepared in the setup cycle so that they
  // leave flops; the price is that every transfer takes exactly two cycles.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~(hit_ctrl | hit_stat | hit_cfg);
      if (setup && !pwrite) begin
        if (hit_ctrl) begin
          prdata <= {24'h00_0000, ctrl_q};
        end else if (hit_stat) begin
          prdata <= status_word;
        end else if (hit_cfg) begin
          prdata <= {31'h0000_0000, mute_force_q};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Writes land only at the completing edge; the control word is read-only.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mute_force_q <= `CRG_CFG_RESET;
    end else if (access && pwrite && hit_cfg) begin
      mute_force_q <= pwdata[`CRG_CFG_MUTE_FORCE];
    end
  end

  // Writing one to the loaded bit clears it.
  assign loaded_clr = access & pwrite & hit_stat & pwdata[`CRG_ST_LOADED];

  // ------------------------------------------------------------------
  // Checks in the system domain.
  // ------------------------------------------------------------------
  sequence load_edge_s;
    strobe_rise && ctrl_rst_n;
  endsequence

  sequence released_quiet_s;
    $rose(ctrl_rst_n) ##0 !strobe_rise [*4];
  endsequence

  // A register reset that drops between the load and the check aborts the attempt.
  property word_loaded_p;
    @(posedge clk) disable iff (!ctrl_rst_n)
    load_edge_s |=> ctrl_q == $past(shift_q);
  endproperty

  property mute_from_word_p;
    @(posedge clk) disable iff (!ctrl_rst_n)
    load_edge_s ##1 ctrl_rst_n |=>
      mic_mute_q == ($past(shift_q[`CRG_MUTE_BIT], 2) | $past(mute_force_q));
  endproperty

  clear_in_reset_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ1
    (!reset_hold_input && !ctrl_rst_n) |-> ctrl_q == 8'h00 && !mic_mute_q)
    else $error("Control word not clear while reset is held");

  drop_in_reset_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
    (strobe_rise && !ctrl_rst_n) |=> ctrl_q == 8'h00)
    else $error("Word stored during reset");

  stay_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ3
    released_quiet_s |-> ctrl_q == 8'h00)
    else $error("Control word not zero after reset release");

  mute_output_a: assert property (mute_from_word_p) // RQ4
    else $error("Mute output does not follow the loaded word");

  block_power_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    (pd_s && power_down_input) |-> ctrl_q == 8'h00 && !ctrl_rst_n)
    else $error("Register accepted data while powered down");

  clear_enable_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    $fell(pd_s) |-> ctrl_q == 8'h00 ##1 (ctrl_q == 8'h00 || $past(strobe_rise)))
    else $error("Register not cleared on leaving power-down");

  release_sync_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
    $rose(ctrl_rst_n) |-> $past(gate_n) && $past(gate_n, 2))
    else $error("Reset released without two clean clocks");

  load_word_a: assert property (word_loaded_p) // RQ9
    else $error("Strobe rise did not transfer the shifted word");

  field_layout_a: assert property (@(posedge clk) disable iff (!ctrl_rst_n) // RQ10
    $past(ctrl_rst_n) |-> volume_q == $past(ctrl_q[3:0]) &&
      range_narrow_q == $past(ctrl_q[5]))
    else $error("Volume or range field misplaced");

  mode_decode_a: assert property (@(posedge clk) disable iff (!ctrl_rst_n) // RQ11
    $past(ctrl_rst_n) |-> force_idle_q == $past(ctrl_q[7]) &&
      force_receive_q == ($past(ctrl_q[7:6]) == 2'b01) &&
      voice_switch_q == ($past(ctrl_q[7:6]) == 2'b00) &&
      volume_active_q == force_receive_q)
    else $error("Mode field decoded wrongly");

endmodule : crg_top

// ---- pkg/crg_map.svh ----
`ifndef CRG_MAP_SVH
`define CRG_MAP_SVH

// Register byte offsets on the bus.
`define CRG_OFF_CTRL_WORD  12'h000
`define CRG_OFF_STATUS     12'h004
`define CRG_OFF_CONFIG     12'h008

// Control word field positions.
`define CRG_VOL_LSB        0
`define CRG_VOL_MSB        3
`define CRG_MUTE_BIT       4
`define CRG_RANGE_BIT      5
`define CRG_MODE_LSB       6
`define CRG_MODE_MSB       7

// Status register field positions.
`define CRG_ST_PWR_DOWN    0
`define CRG_ST_RST_HOLD    1
`define CRG_ST_LOADED      2
`define CRG_ST_CNT_LSB     8
`define CRG_ST_CNT_MSB     15

// Configuration register field positions.
`define CRG_CFG_MUTE_FORCE 0

// Reset values.
`define CRG_CTRL_RESET     8'h00
`define CRG_CFG_RESET      1'b0

// Word length and synchroniser depth.
`define CRG_WORD_BITS      8
`define CRG_SYNC_STAGES    2

`endif

// ---- pkg/crg_pkg.sv ----
package crg_pkg;

  // Operating mode held in the two top bits of the control word.
  typedef enum logic [1:0] {
    CRG_MODE_VOICE   = 2'b00,
    CRG_MODE_RECEIVE = 2'b01,
    CRG_MODE_IDLE_A  = 2'b10,
    CRG_MODE_IDLE_B  = 2'b11
  } crg_mode_type;

endpackage : crg_pkg

// ---- src/crg_sync.sv ----
`timescale 1ns/1ns
// Two-flop level synchroniser; only the second stage is visible outside.
module crg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,      // Destination clock.
  input  wire logic             reset_n,  // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] async_in, // Level from another domain.
  output logic      [WIDTH-1:0] sync_out  // Synchronised level.
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : crg_sync

// ---- src/crg_rst_sync.sv ----
`timescale 1ns/1ns
// Reset that asserts at once and releases on the second edge of clk.
module crg_rst_sync (
  input  wire logic clk,     // Clock of the domain to be reset.
  input  wire logic arst_n,  // Raw reset request, active low.
  output logic      rst_n    // Domain reset, active low.
);

  logic stage_q;

  // Assertion needs no clock; release is delayed so that no flop sees a runt.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      stage_q <= 1'b1;
      rst_n   <= stage_q;
    end
  end

endmodule : crg_rst_sync

// ---- testbench/crg_host.sv ----
`timescale 1ns/1ns
// Host controller model; it owns the serial clock, which stands still between frames.
module crg_host (
  output logic serial_clk,  // Serial clock, idle low.
  output logic serial_data, // Serial data.
  output logic load_strobe  // Low while shifting.
);
  // The strobe idles high so stray edges on the lines do no harm.
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b1;
  end

  // One clock pulse, stretched by the given factor for a slow host.
  task automatic pulse(input int slow);
    #(24 * slow) serial_clk = 1'b1;
    #(24 * slow) serial_clk = 1'b0;
  endtask : pulse

  // Two leading pulses with the strobe high let the shift stage leave reset first.
  task automatic send(input logic [7:0] w, input int slow);
    #7;
    repeat (2) pulse(slow);
    load_strobe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_data = w[i];
      pulse(slow);
    end
    serial_data = ~w[0];  // Released data shows the inverse of the last bit.
    load_strobe = 1'b1;
    #200;
  endtask : send
endmodule : crg_host

// ---- testbench/control_register_reset_gating_tb.sv ----
`timescale 1ns/1ns
`include "crg_map.svh"
// Bench that loads words serially and compares register and pins with a word model.
module control_register_reset_gating_tb;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        serial_clk, serial_data, load_strobe, reset_hold_input, power_down_input;
  logic        mic_mute_q, range_narrow_q, volume_active_q;
  logic        voice_switch_q, force_receive_q, force_idle_q;
  logic [3:0]  volume_q;
  logic [7:0]  w;
  int          bad_count, comparisons, cfg, nloads;
  int          words[$];
  wire  [9:0]  pins = {force_idle_q, force_receive_q, voice_switch_q, volume_active_q,
                       range_narrow_q, mic_mute_q, volume_q};

  crg_top DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_clk, .serial_data, .load_strobe, .reset_hold_input, .power_down_input,
    .mic_mute_q, .range_narrow_q, .volume_q, .volume_active_q, .voice_switch_q,
    .force_receive_q, .force_idle_q);
  crg_host host (.serial_clk, .serial_data, .load_strobe);

  // The system clock runs free at 50 MHz.
  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // The model word is the last accepted load, or zero once a clear has emptied the queue.
  task automatic check(input string nm);
    logic [7:0] e;
    logic [1:0] m;
    repeat (8) @(posedge clk);
    e = (words.size() > 0) ? 8'(words[$]) : 8'h00;
    m = e[7:6];
    apb(1'b0, `CRG_OFF_CTRL_WORD, 32'h0);
    chk(nm, rd, {24'h0, e});
    chk(nm, pins, {m[1], m == 2'b01, m == 2'b00, m == 2'b01, e[5], e[4] | cfg[0], e[3:0]});
  endtask : check

  task automatic load(input logic [7:0] v, input int slow, input bit takes);
    host.send(v, slow);
    if (takes) begin
      words.push_back(v);
      nloads++;
    end
  endtask : load

  task automatic summarize;
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // A hang is cut short long after the whole sequence should have ended.
  initial begin
    #400000;
    bad_count++;
    summarize;
  end

  // Main sequence: modes, register reset, power-down, then the bus registers.
  initial begin
    void'($urandom(32'hFD60));
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {reset_hold_input, power_down_input, bad_count, comparisons, cfg, nloads} =
      {1'b1, 1'b0, 128'h0};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    check("reset word");
    for (int m = 0; m < 4; m++) begin
      w = {m[1:0], 6'($urandom())};
      w[4] = m[0];
      load(w, 1 + m % 2, 1'b1);
      check("mode word");
    end
    reset_hold_input <= 1'b0;
    words.delete();
    check("hold clear");
    apb(1'b0, `CRG_OFF_STATUS, 32'h0);
    chk("status hold", rd, {16'h0, 8'(nloads), 8'h06});
    load(8'hFF, 1, 1'b0);
    @(posedge clk);
    reset_hold_input <= 1'b1;
    check("after hold");
    load(8'h7C, 1, 1'b1);
    check("reload");
    power_down_input <= 1'b1;
    load(8'h5A, 1, 1'b0);
    apb(1'b0, `CRG_OFF_STATUS, 32'h0);
    chk("status down", rd, {16'h0, 8'(nloads), 8'h05});
    power_down_input <= 1'b0;
    words.delete();
    check("power up");
    apb(1'b1, `CRG_OFF_STATUS, 32'h4);
    apb(1'b0, `CRG_OFF_STATUS, 32'h0);
    chk("status clear", rd, {16'h0, 8'(nloads), 8'h00});
    apb(1'b1, `CRG_OFF_CONFIG, 32'h1);
    cfg = 1;
    check("mute force");
    apb(1'b1, `CRG_OFF_CTRL_WORD, 32'hFF);
    check("ro write");
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `CRG_OFF_CONFIG, 32'h0);
    cfg = 0;
    check("mute off");
    summarize;
  end
endmodule : control_register_reset_gating_tb
